// file: hdl/twm_pkg.sv
package twm_pkg;
    localparam int CNT_W = 8;
    localparam logic [7:0] BOTTOM = 8'h00;
    localparam logic [7:0] MAX_VAL = 8'hFF;
    // Register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_CMPA = 8'h04;
    localparam logic [7:0] REG_CMPB = 8'h08;
    localparam logic [7:0] REG_COUNT = 8'h0C;
    localparam logic [7:0] REG_FLAGS = 8'h10;
    // Control field positions
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_ACTA_LSB = 4;
    localparam int CTRL_ACTB_LSB = 6;
    localparam int CTRL_RUN_BIT = 8;
    localparam int CTRL_DIV_LSB = 16;
    // Flag bit positions
    localparam int FLAG_OVF = 0;
    localparam int FLAG_CMPA = 1;
    localparam int FLAG_CMPB = 2;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    // Waveform modes
    typedef enum logic [2:0] {
        MODE_NORMAL = 3'b000,
        MODE_PC_FF = 3'b001,
        MODE_CLEAR_ON_MATCH = 3'b010,
        MODE_FAST_FF = 3'b011,
        MODE_RSV4 = 3'b100,
        MODE_PC_CMPA = 3'b101,
        MODE_RSV6 = 3'b110,
        MODE_FAST_CMPA = 3'b111
    } twm_mode_t;
    typedef struct packed {
        logic [15:0] prescale;
        logic run;
        logic [1:0] output_action_b;
        logic [1:0] output_action_a;
        twm_mode_t waveform_mode_sel;
    } twm_ctrl_t;
    typedef struct packed {
        logic wave_out_a;
        logic wave_out_b;
        logic drive_a;
        logic drive_b;
    } twm_pins_t;
endpackage

// file: hdl/twm_timer.sv
`timescale 1ns/1ns
// How it works
// RULE1: Mode 2 counts up, clears at compare A
// RULE2: Mode 2 compare writes immediate, may miss
// RULE3: Mode 2 sets compare flag A at top
// RULE4: Mode 2 action 1 toggles output A
// RULE5: Software enables pin direction for output
// RULE6: Mode 2 overflow flag on MAX to zero
// RULE7: Modes 3,7 fast PWM, top FF or A
// RULE8: Fast PWM clears counter after top
// RULE9: Fast PWM match clears, bottom sets output
// RULE10: Action two non-inverted, three inverted PWM
// RULE11: Fast PWM overflow flag at top
// RULE12: Action one toggles A only if bit2
// RULE13: Fast PWM FF period 256 ticks
// RULE14: Fast PWM extremes give spike or constant
// RULE15: Fast PWM keeps compare buffering, toggle too
// RULE16: Modes 1,5 dual slope, top FF or A
// RULE17: Reverse at top, top held one tick
// RULE18: Up match clears, down match sets output
// RULE19: Phase correct overflow flag at bottom
// RULE20: Phase correct FF period 510 ticks
// RULE21: Extremes give constant low or high
// RULE22: Bottom forces down-match level without match
// RULE23: PWM writes buffered, others direct
// RULE24: Action zero leaves output, disconnects pin
// RULE25: Match flag next tick, write one clears
// RULE26: Load buffer at bottom fast, top PC
// RULE27: Top from A: set/clear at bottom/top
module twm_timer
    import twm_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input wire logic aclk, // Clock
    input wire logic aresetn, // Sync reset, low
    input wire logic [ADDR_W-1:0] s_axi_awaddr, // Write address
    input wire logic s_axi_awvalid, // Write address valid
    output logic s_axi_awready, // Write address ready
    input wire logic [31:0] s_axi_wdata, // Write data
    input wire logic [3:0] s_axi_wstrb, // Byte strobes
    input wire logic s_axi_wvalid, // Write data valid
    output logic s_axi_wready, // Write data ready
    output logic [1:0] s_axi_bresp, // Write response
    output logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    input wire logic [ADDR_W-1:0] s_axi_araddr, // Read address
    input wire logic s_axi_arvalid, // Read address valid
    output logic s_axi_arready, // Read address ready
    output logic [31:0] s_axi_rdata, // Read data
    output logic [1:0] s_axi_rresp, // Read response
    output logic s_axi_rvalid, // Read data valid
    input wire logic s_axi_rready, // Read data ready
    input wire logic irq_ack_ovf, // Overflow vector serviced
    input wire logic irq_ack_cmpa, // Compare A vector serviced
    input wire logic irq_ack_cmpb, // Compare B vector serviced
    output twm_pins_t pins, // Waveforms and pin overrides
    output logic overflow_flag, // Overflow flag
    output logic compare_flag_a, // Compare A flag
    output logic compare_flag_b // Compare B flag
);
    initial begin
        if (ADDR_W < 8) begin
            $error("ADDR_W too small for register map");
        end
    end

    twm_ctrl_t ctrl_q;
    logic [7:0] count_value_q;
    logic dir_down_q;
    logic [7:0] compare_value_a_q, compare_value_b_q;
    logic [7:0] buf_a_q, buf_b_q;
    logic wave_a_q, wave_b_q;
    logic ovf_q, cfa_q, cfb_q;
    logic [15:0] div_q;
    logic tick;
    logic [ADDR_W-1:0] awaddr_q;
    logic aw_have_q, w_have_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic [31:0] rdata_q;
    logic rvalid_q, bvalid_q;
    logic [1:0] bresp_q, rresp_q;

    twm_mode_t mode;
    logic is_fast, is_pc, is_pwm, top_from_a;
    logic [7:0] top;
    logic at_top, at_bottom, match_a, match_b;
    logic wr_go, rd_go;
    logic wr_ctrl, wr_cmpa, wr_cmpb, wr_count, wr_flags;
    logic block_q;

    assign mode = ctrl_q.waveform_mode_sel;
    assign is_fast = (mode == MODE_FAST_FF) || (mode == MODE_FAST_CMPA); // RULE7
    assign is_pc = (mode == MODE_PC_FF) || (mode == MODE_PC_CMPA); // RULE16
    assign is_pwm = is_fast || is_pc;
    assign top_from_a = (mode == MODE_CLEAR_ON_MATCH) ||
        (mode == MODE_FAST_CMPA) || (mode == MODE_PC_CMPA);
    assign top = top_from_a ? compare_value_a_q : MAX_VAL; // RULE1
    assign at_top = (count_value_q == top);
    assign at_bottom = (count_value_q == BOTTOM);
    assign match_a = (count_value_q == compare_value_a_q) && !block_q;
    assign match_b = (count_value_q == compare_value_b_q) && !block_q;

    // Timer tick: prescaled enable; divisor 0 means every clock
    assign tick = ctrl_q.run && (div_q == 16'h0000);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_q <= 16'h0000;
        end else if (!ctrl_q.run || div_q == 16'h0000) begin
            div_q <= ctrl_q.prescale;
        end else begin
            div_q <= div_q - 16'h0001;
        end
    end

    // AXI write path: address and data taken in either order
    assign s_axi_awready = !aw_have_q && !bvalid_q;
    assign s_axi_wready = !w_have_q && !bvalid_q;
    assign wr_go = aw_have_q && w_have_q && !bvalid_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            awaddr_q <= '0;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q <= (wr_ctrl || wr_cmpa || wr_cmpb || wr_count ||
                    wr_flags) ? RESP_OKAY : RESP_SLVERR;
            end else if (bvalid_q && s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;

    assign wr_ctrl = wr_go && awaddr_q[7:0] == REG_CTRL;
    assign wr_cmpa = wr_go && awaddr_q[7:0] == REG_CMPA && wstrb_q[0];
    assign wr_cmpb = wr_go && awaddr_q[7:0] == REG_CMPB && wstrb_q[0];
    assign wr_count = wr_go && awaddr_q[7:0] == REG_COUNT && wstrb_q[0];
    assign wr_flags = wr_go && awaddr_q[7:0] == REG_FLAGS && wstrb_q[0];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q <= '0;
        end else if (wr_ctrl) begin
            if (wstrb_q[0]) begin
                ctrl_q.waveform_mode_sel <= twm_mode_t'(wdata_q[2:0]);
                ctrl_q.output_action_a <= wdata_q[5:4];
                ctrl_q.output_action_b <= wdata_q[7:6];
            end
            if (wstrb_q[1]) begin
                ctrl_q.run <= wdata_q[CTRL_RUN_BIT];
            end
            if (wstrb_q[2]) begin
                ctrl_q.prescale[7:0] <= wdata_q[23:16];
            end
            if (wstrb_q[3]) begin
                ctrl_q.prescale[15:8] <= wdata_q[31:24];
            end
        end
    end

    // Compare buffers; active copy updated directly outside PWM
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            buf_a_q <= 8'h00;
            buf_b_q <= 8'h00;
            compare_value_a_q <= 8'h00;
            compare_value_b_q <= 8'h00;
        end else begin
            if (wr_cmpa) begin
                buf_a_q <= wdata_q[7:0];
            end
            if (wr_cmpb) begin
                buf_b_q <= wdata_q[7:0];
            end
            if (!is_pwm) begin
                // No buffering: a value below count is missed until wrap
                if (wr_cmpa) begin
                    compare_value_a_q <= wdata_q[7:0]; // RULE2 RULE23
                end
                if (wr_cmpb) begin
                    compare_value_b_q <= wdata_q[7:0]; // RULE23
                end
            end else if (tick && ((is_fast && at_top) ||
                    (is_pc && at_top && !dir_down_q))) begin
                // Loaded as count goes to bottom (fast) or sits at top
                compare_value_a_q <= buf_a_q; // RULE15 RULE23 RULE26
                compare_value_b_q <= buf_b_q; // RULE26
            end
        end
    end

    // Count sequence
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count_value_q <= 8'h00;
            dir_down_q <= 1'b0;
            block_q <= 1'b0;
        end else if (wr_count) begin
            count_value_q <= wdata_q[7:0];
            block_q <= 1'b1;
        end else if (tick) begin
            block_q <= 1'b0;
            if (is_pc) begin
                if (!dir_down_q && at_top) begin
                    dir_down_q <= 1'b1; // RULE17
                    count_value_q <= count_value_q - 8'h01;
                end else if (dir_down_q && at_bottom) begin
                    dir_down_q <= 1'b0;
                    count_value_q <= count_value_q + 8'h01; // RULE20
                end else if (dir_down_q) begin
                    count_value_q <= count_value_q - 8'h01;
                end else begin
                    count_value_q <= count_value_q + 8'h01;
                end
            end else begin
                dir_down_q <= 1'b0;
                if ((mode == MODE_CLEAR_ON_MATCH || is_fast) && at_top) begin
                    count_value_q <= BOTTOM; // RULE1 RULE8 RULE13
                end else begin
                    count_value_q <= count_value_q + 8'h01;
                end
            end
        end
    end

    // Waveform generation per channel
    function automatic logic wave_next(input logic cur, input logic [1:0] act,
        input logic match, input logic allow_tog, input logic use_top);
        logic inv;
        logic lvl;
        logic dn;
        inv = act[0];
        lvl = cur;
        dn = at_top || (dir_down_q && !at_bottom);
        if (act == 2'b00) begin
            lvl = cur; // RULE24
        end else if (act == 2'b01) begin
            if ((!is_pwm || allow_tog) && match) begin
                lvl = !cur; // RULE4 RULE12
            end
        end else if (is_fast) begin
            // Match first, bottom level last: a top compare is ignored
            // and gives a constant level, a zero compare a one-tick spike
            if (match && !use_top) begin
                lvl = inv; // RULE9 RULE10
            end
            if (at_top) begin
                lvl = !inv; // RULE9 RULE14 RULE27
            end
        end else if (is_pc) begin
            if (use_top && at_top && !dir_down_q) begin
                lvl = inv; // RULE27
            end else if (match && !use_top) begin
                // Top match acts as down-count, bottom match as up-count
                lvl = dn ? !inv : inv; // RULE18 RULE10 RULE21
            end else if (dir_down_q && at_bottom) begin
                lvl = !inv; // RULE22
            end
        end else begin
            if (match) begin
                lvl = inv;
            end
        end
        return lvl;
    endfunction

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wave_a_q <= 1'b0;
            wave_b_q <= 1'b0;
        end else if (tick) begin
            wave_a_q <= wave_next(wave_a_q, ctrl_q.output_action_a, match_a,
                mode[2], top_from_a && is_pwm && ctrl_q.output_action_a[1]);
            wave_b_q <= wave_next(wave_b_q, ctrl_q.output_action_b, match_b,
                1'b0, 1'b0);
        end
    end

    // Pin drive: software's pin direction gates visibility outside
    assign pins.wave_out_a = wave_a_q;
    assign pins.wave_out_b = wave_b_q;
    assign pins.drive_a = (ctrl_q.output_action_a != 2'b00) &&
        !(is_pwm && ctrl_q.output_action_a == 2'b01 && !mode[2]); // RULE24
    assign pins.drive_b = (ctrl_q.output_action_b != 2'b00) &&
        !(is_pwm && ctrl_q.output_action_b == 2'b01); // RULE12

    // Flags: hardware set beats clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ovf_q <= 1'b0;
            cfa_q <= 1'b0;
            cfb_q <= 1'b0;
        end else begin
            if (tick && ((is_fast && at_top) || // RULE11
                (is_pc && dir_down_q && at_bottom) || // RULE19
                (!is_pwm && count_value_q == MAX_VAL))) begin // RULE6
                ovf_q <= 1'b1;
            end else if ((wr_flags && wdata_q[FLAG_OVF]) || irq_ack_ovf) begin
                ovf_q <= 1'b0;
            end
            if (tick && match_a) begin
                cfa_q <= 1'b1; // RULE3 RULE25
            end else if ((wr_flags && wdata_q[FLAG_CMPA]) || irq_ack_cmpa) begin
                cfa_q <= 1'b0; // RULE25
            end
            if (tick && match_b) begin
                cfb_q <= 1'b1;
            end else if ((wr_flags && wdata_q[FLAG_CMPB]) || irq_ack_cmpb) begin
                cfb_q <= 1'b0;
            end
        end
    end
    assign overflow_flag = ovf_q;
    assign compare_flag_a = cfa_q;
    assign compare_flag_b = cfb_q;

    // AXI read path
    assign s_axi_arready = !rvalid_q;
    assign rd_go = s_axi_arvalid && s_axi_arready;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= RESP_OKAY;
        end else if (rd_go) begin
            rvalid_q <= 1'b1;
            rresp_q <= RESP_OKAY;
            case (s_axi_araddr[7:0])
                REG_CTRL: rdata_q <= {ctrl_q.prescale, 7'h00, ctrl_q.run,
                    ctrl_q.output_action_b, ctrl_q.output_action_a, 1'b0,
                    ctrl_q.waveform_mode_sel};
                REG_CMPA: rdata_q <= {24'h00_0000, buf_a_q};
                REG_CMPB: rdata_q <= {24'h00_0000, buf_b_q};
                REG_COUNT: rdata_q <= {24'h00_0000, count_value_q};
                REG_FLAGS: rdata_q <= {29'h0000_0000, cfb_q, cfa_q, ovf_q};
                default: begin
                    rdata_q <= 32'h0000_0000;
                    rresp_q <= RESP_SLVERR;
                end
            endcase
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
endmodule

// file: testbench/twm_timer_assertions.sv
`timescale 1ns/1ns
module twm_timer_assertions
    import twm_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input wire logic aclk, // Clock
    input wire logic aresetn, // Sync reset, low
    input wire logic [ADDR_W-1:0] s_axi_awaddr, // Write address
    input wire logic s_axi_awvalid, // Address valid
    input wire logic s_axi_awready, // Address ready
    input wire logic [31:0] s_axi_wdata, // Write data
    input wire logic [3:0] s_axi_wstrb, // Strobes
    input wire logic s_axi_wvalid, // Data valid
    input wire logic s_axi_wready, // Data ready
    input wire logic s_axi_bvalid, // Response valid
    input wire logic s_axi_arvalid, // Read address valid
    input wire logic s_axi_arready, // Read address ready
    input wire logic [31:0] s_axi_rdata, // Read data
    input wire logic [1:0] s_axi_rresp, // Read response
    input wire logic s_axi_rvalid, // Read valid
    input wire twm_pins_t pins // Waveforms and overrides
);
    twm_ctrl_t ctl_q;
    twm_mode_t md;
    logic [7:0] cmpa_q;
    logic [9:0] stab_q;
    logic [1:0] aa;
    logic wr_ok, pwm, exp_da, exp_db, settled, base;
    // Shadow sees only full words taken on one edge, as the bench issues
    assign wr_ok = s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready && s_axi_wstrb == 4'hf;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctl_q <= '0;
            cmpa_q <= '0;
            stab_q <= '0;
        end else if (wr_ok) begin
            stab_q <= '0;
            if (s_axi_awaddr == ADDR_W'(REG_CTRL))
                ctl_q <= {s_axi_wdata[31:16], s_axi_wdata[8],
                    s_axi_wdata[7:4], s_axi_wdata[2:0]};
            if (s_axi_awaddr == ADDR_W'(REG_CMPA))
                cmpa_q <= s_axi_wdata[7:0];
        end else if (stab_q != 10'h3ff) begin
            stab_q <= stab_q + 10'h001;
        end
    end
    assign md = ctl_q.waveform_mode_sel;
    assign aa = ctl_q.output_action_a;
    assign pwm = md[0];
    assign exp_da = aa != 2'h0 && !(aa == 2'h1 && pwm && !md[2]);
    assign exp_db = ctl_q.output_action_b != 2'h0
        && !(ctl_q.output_action_b == 2'h1 && pwm);
    // Long settle so buffered compare values have surely loaded
    assign settled = stab_q > 10'h320;
    assign base = settled && ctl_q.run && ctl_q.prescale == 16'h0000;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_toggle;
        ##1 pins.wave_out_a != $past(pins.wave_out_a);
    endsequence
    sequence s_spike;
        !pins.wave_out_a ##255 pins.wave_out_a;
    endsequence

    a_drive_a_map:
        assert property (stab_q > 10'h002 |-> pins.drive_a == exp_da)
        else $error("Output A override wrong");
    a_drive_b_map:
        assert property (stab_q > 10'h002 |-> pins.drive_b == exp_db)
        else $error("Output B override wrong");
    a_ctc_toggle:
        assert property (disable iff (!aresetn || !settled)
            base && md == MODE_CLEAR_ON_MATCH && aa == 2'h1
            && cmpa_q == 8'h00 |-> s_toggle)
        else $error("Output A not toggling each clock");
    a_pc_level:
        assert property (base && md == MODE_PC_FF && aa[1]
            && (cmpa_q == 8'h00 || cmpa_q == 8'hff)
            |-> pins.wave_out_a == ((cmpa_q == 8'hff) ^ aa[0]))
        else $error("Phase correct extreme level wrong");
    a_fast_spike:
        assert property (disable iff (!aresetn || !settled)
            base && md == MODE_FAST_FF && aa == 2'h2 && cmpa_q == 8'h00
            && $rose(pins.wave_out_a) |=> s_spike)
        else $error("Fast spike width or period wrong");
    a_write_answer:
        assert property (wr_ok |-> ##2 s_axi_bvalid)
        else $error("Write response late");
    a_read_answer:
        assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("Read data late");
    a_slverr_zero:
        assert property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR
            |-> s_axi_rdata == 32'h0000_0000)
        else $error("Refused read returned data");
endmodule

bind twm_timer twm_timer_assertions #(.ADDR_W(ADDR_W)) u_chk (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .pins(pins)
);

// file: testbench/tb.sv
`timescale 1ns/1ns
module tb;
    import twm_pkg::*;
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic awvalid = 1'h0;
    logic wvalid = 1'h0;
    logic arvalid = 1'h0;
    logic [2:0] ack = 3'h0;
    logic [2:0] fl;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic awready, wready, bvalid, arready, rvalid;
    twm_pins_t pins;
    int fails = 0;
    int checks = 0;

    always #10 aclk = ~aclk;

    twm_timer #(.ADDR_W(8)) u_dut (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'h1),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(1'h1),
        .irq_ack_ovf(ack[0]), .irq_ack_cmpa(ack[1]),
        .irq_ack_cmpb(ack[2]), .pins(pins), .overflow_flag(fl[0]),
        .compare_flag_a(fl[1]), .compare_flag_b(fl[2])
    );

    task automatic test_done;
        if (fails == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, exp, input string m);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("FAIL %0t %s", $time, m);
        end
    endtask
    task automatic lost;
        chk(1'h0, 1'h1, "handshake timeout");
        test_done;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er = RESP_OKAY);
        int n;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
            if (bvalid) break;
        end
        if (n == 50) lost();
        chk(bresp, er, "write response");
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        int n;
        araddr <= a;
        arvalid <= 1'h1;
        for (n = 0; n < 50; n++) begin
            @(posedge aclk);
            if (arready) arvalid <= 1'h0;
            if (rvalid) break;
        end
        if (n == 50) lost();
        d = rdata;
        r = rresp;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e,
                       input logic [1:0] er = RESP_OKAY);
        logic [31:0] d;
        logic [1:0] r;
        rd(a, d, r);
        chk(d, e, "read data");
        chk(r, er, "read response");
    endtask
    task automatic wflag(input int b, input int lim);
        int n;
        for (n = 0; n < lim && fl[b] !== 1'h1; n++) @(posedge aclk);
        chk(fl[b], 1'h1, "flag not raised");
    endtask
    // Cycles between two rising edges of output A, -1 if none
    task automatic per(output int p);
        int n, k;
        logic pv;
        k = -1;
        p = -1;
        pv = pins.wave_out_a;
        for (n = 0; n < 1200 && p < 0; n++) begin
            @(posedge aclk);
            if (pins.wave_out_a === 1'h1 && pv === 1'h0) begin
                if (k >= 0) p = n - k;
                k = n;
            end
            pv = pins.wave_out_a;
        end
    endtask
    function automatic logic [31:0] cfg(input twm_mode_t m,
        input logic [1:0] a, b, input logic run);
        return {16'h0000, 7'h00, run, b, a, 1'h0, m};
    endfunction

    initial begin
        logic [31:0] d;
        logic [1:0] r;
        logic [7:0] c;
        int p, i;
        cyc(4);
        aresetn <= 1'h1;
        cyc(1);
        rdc(REG_CTRL, 32'h0000_0000);
        rdc(REG_FLAGS, 32'h0000_0000);
        rdc(8'h20, 32'h0000_0000, RESP_SLVERR);
        wr(8'h20, 32'hffff_ffff, RESP_SLVERR);
        rdc(REG_CTRL, 32'h0000_0000);
        wr(REG_CMPA, 32'h0000_0004);
        wr(REG_CMPB, 32'h0000_0002);
        wr(REG_CTRL, cfg(MODE_CLEAR_ON_MATCH, 2'h0, 2'h0, 1'h1));
        for (i = 0; i < 12; i++) begin
            rd(REG_COUNT, d, r);
            chk(d <= 32'h0000_0004, 1'h1, "count past top");
        end
        chk(fl, 3'h6, "flags in clear mode");
        chk(pins.drive_a, 1'h0, "action zero drives");
        wr(REG_CTRL, cfg(MODE_CLEAR_ON_MATCH, 2'h0, 2'h0, 1'h0));
        wr(REG_FLAGS, 32'h0000_0002);
        chk(fl, 3'h4, "write one clear");
        wr(REG_COUNT, 32'h0000_0010);
        wr(REG_CTRL, cfg(MODE_CLEAR_ON_MATCH, 2'h0, 2'h0, 1'h1));
        wflag(0, 300);
        cyc(10);
        wr(REG_CTRL, cfg(MODE_CLEAR_ON_MATCH, 2'h0, 2'h0, 1'h0));
        chk(fl, 3'h7, "flags after wrap");
        for (i = 0; i < 3; i++) begin
            ack[i] <= 1'h1;
            cyc(1);
            ack[i] <= 1'h0;
            cyc(1);
            chk(fl[i], 1'h0, "service clear");
        end
        wr(REG_CMPA, 32'h0000_0000);
        wr(REG_CTRL, cfg(MODE_CLEAR_ON_MATCH, 2'h1, 2'h0, 1'h1));
        cyc(800);
        per(p);
        chk(p, 2, "toggle period");
        wr(REG_CTRL, cfg(MODE_FAST_FF, 2'h2, 2'h0, 1'h1));
        wr(REG_FLAGS, 32'h0000_0007);
        wflag(0, 300);
        cyc(700);
        per(p);
        chk(p, 256, "fast spike period");
        // Extremes: fast at max, phase correct at bottom and max
        for (i = 0; i < 6; i++) begin
            c = (i == 2 || i == 3) ? 8'h00 : 8'hff;
            wr(REG_CTRL, cfg(i < 2 ? MODE_FAST_FF : MODE_PC_FF,
                2'h2 + 2'(i % 2), 2'h0, 1'h1));
            wr(REG_CMPA, 32'(c));
            cyc(800);
            chk(pins.wave_out_a, (c == 8'hff) ^ (i % 2), "level");
            cyc(300);
            chk(pins.wave_out_a, (c == 8'hff) ^ (i % 2), "level");
        end
        wr(REG_CMPA, 32'h0000_0080);
        wr(REG_FLAGS, 32'h0000_0007);
        wflag(0, 600);
        cyc(600);
        per(p);
        chk(p, 510, "phase correct period");
        wr(REG_CTRL, cfg(MODE_FAST_FF, 2'h1, 2'h1, 1'h1));
        cyc(2);
        chk({pins.drive_a, pins.drive_b}, 2'h0, "action one");
        wr(REG_CTRL, cfg(MODE_FAST_CMPA, 2'h1, 2'h2, 1'h1));
        wr(REG_CMPA, 32'h0000_0009);
        cyc(600);
        chk({pins.drive_a, pins.drive_b}, 2'h3, "action one");
        // One full period of ten ticks; B high for counts 0 to 2
        c = 8'h00;
        for (i = 0; i < 10; i++) begin
            cyc(1);
            c = c + 8'(pins.wave_out_b);
        end
        chk(c, 8'h03, "output B duty");
        per(p);
        chk(p, 20, "fast top from A");
        wr(REG_CTRL, cfg(MODE_PC_CMPA, 2'h1, 2'h0, 1'h1));
        cyc(300);
        per(p);
        chk(p, 36, "phase correct top from A");
        test_done;
    end
endmodule
